// ===== design/vat_translator.v
`timescale 1ns/1ns
`include "vat_defines.vh"

// Summary of operation
// - wide kernel top segment: mapped or window
// - window only when bits 61-31 all ones
// - first window direct, policy from config field
// - second window direct and uncached
// - third and fourth windows go through translator
// - 48 fully associative even/odd page pairs
// - 32-bit entry: mask, pair, global, tag
// - 64-bit entry adds region matched to 63-62
// - store to unwritable page: modification fault
// - usable flag not matched; clear gives invalid
// - tag ignored only if both halves global
// - non-global entries compare 8-bit tag
// - compare 7-19 or 15-27 page bits
// - hit returns frame, attribute, writable, usable
// - no match raises refill fault
// - reserved entry bits read as zero
// - two-entry instruction micro translator, hidden
// - four-entry data micro translator, hidden
// - probe, read, indexed write, random write
module vat_translator
(
    input  wire                        mclk,
    input  wire                        rst,
    input  wire                        wideKernelAddressing,
    input  wire                        kernelMode,
    input  wire                        wideMode,
    input  wire [2:0]                  directWindowCachePolicy,
    input  wire [`VAT_TAG_W-1:0]       processTag,
    input  wire                        reqValid,
    input  wire                        reqIsData,
    input  wire                        reqIsStore,
    input  wire [63:0]                 reqVaddr,
    output reg                         rspValid_q,
    output reg                         rspMapped_q,
    output reg  [`VAT_PA_W-1:0]        rspPaddr_q,
    output reg  [2:0]                  rspAttr_q,
    output reg                         rspWritable_q,
    output reg                         rspUsable_q,
    output reg                         rspUncached_q,
    output reg                         rspRefill_q,
    output reg                         rspInvalid_q,
    output reg                         rspModify_q,
    input  wire                        opValid,
    input  wire [1:0]                  opCode,
    input  wire [`VAT_IDX_W-1:0]       opIndex,
    input  wire [`VAT_MASK_W-1:0]      opMask,
    input  wire [`VAT_VPN_W-1:0]       opPair,
    input  wire [1:0]                  opRegion,
    input  wire [`VAT_TAG_W-1:0]       opTag,
    input  wire [`VAT_LO_W-1:0]        lowEntryHalfEven,
    input  wire [`VAT_LO_W-1:0]        lowEntryHalfOdd,
    output reg                         opDone_q,
    output reg                         probeHit_q,
    output reg  [`VAT_IDX_W-1:0]       probeIndex_q,
    output reg  [`VAT_MASK_W-1:0]      rdMask_q,
    output reg  [`VAT_VPN_W-1:0]       rdPair_q,
    output reg  [1:0]                  rdRegion_q,
    output reg  [`VAT_TAG_W-1:0]       rdTag_q,
    output reg  [`VAT_LO_W-1:0]        rdEven_q,
    output reg  [`VAT_LO_W-1:0]        rdOdd_q
);

////////////////////////////////////////////////////////////////////////////
// joint translator storage; arrays carry no reset, software must fill them

reg [`VAT_MASK_W-1:0] entMask   [0:`VAT_ENTRIES-1];
reg [`VAT_VPN_W-1:0]  entPair   [0:`VAT_ENTRIES-1];
reg [1:0]             entRegion [0:`VAT_ENTRIES-1];
reg [`VAT_TAG_W-1:0]  entTag    [0:`VAT_ENTRIES-1];
reg                   entGlobal [0:`VAT_ENTRIES-1];
reg [`VAT_LO_W-1:0]   entEven   [0:`VAT_ENTRIES-1];
reg [`VAT_LO_W-1:0]   entOdd    [0:`VAT_ENTRIES-1];

reg [`VAT_IDX_W-1:0]  randomIdx_q;
reg [`VAT_IDX_W-1:0]  iMicroIdx_q [0:`VAT_IMICRO-1];
reg [`VAT_IMICRO-1:0] iMicroVal_q;
reg [`VAT_IDX_W-1:0]  dMicroIdx_q [0:`VAT_DMICRO-1];
reg [`VAT_DMICRO-1:0] dMicroVal_q;
reg                   iFillPtr_q;
reg [1:0]             dFillPtr_q;

////////////////////////////////////////////////////////////////////////////
// one comparator bank shared by lookup and probe; an op takes the cycle

wire                   doWrite;
wire [`VAT_IDX_W-1:0]  writeIdx;
wire [`VAT_VPN_W-1:0]  keyPair;
wire [1:0]             keyRegion;
wire [`VAT_TAG_W-1:0]  keyTag;
wire                   keyWide;
wire [`VAT_ENTRIES-1:0] match;

assign doWrite   = opValid & (opCode == `VAT_OP_WINDEX
                            | opCode == `VAT_OP_WRANDOM);
assign writeIdx  = (opCode == `VAT_OP_WRANDOM) ? randomIdx_q : opIndex;
assign keyPair   = opValid ? opPair : reqVaddr[39:13];
assign keyRegion = opValid ? opRegion : reqVaddr[63:62];
assign keyTag    = opValid ? opTag : processTag;
assign keyWide   = wideMode;

genvar gi;
generate
    for (gi = 0; gi < `VAT_ENTRIES; gi = gi + 1)
    begin : g_cmp
        wire [`VAT_VPN_W-1:0] diff;
        wire                  pairOk;
        wire                  regionOk;
        wire                  tagOk;
        // mask bits widen the page and drop low pair bits from compare
        assign diff = (entPair[gi] ^ keyPair)
                    & ~{{(`VAT_VPN_W-`VAT_MASK_W){1'b0}}, entMask[gi]};
        assign pairOk = keyWide ? (diff == {`VAT_VPN_W{1'b0}})
                      : (diff[`VAT_VPN32_W-1:0]
                         == {`VAT_VPN32_W{1'b0}});
        assign regionOk = ~keyWide
                        | (entRegion[gi] == keyRegion);
        assign tagOk = entGlobal[gi]
                     | (entTag[gi] == keyTag);
        // usable flag deliberately absent here
        assign match[gi] = pairOk & regionOk & tagOk;
    end
endgenerate

// on overlapping pairs the lowest index wins, except where a micro hit supplies the index
reg                  jointHit;
reg [`VAT_IDX_W-1:0] jointIdx;
integer k;
always @*
begin
    jointHit = 1'b0;
    jointIdx = {`VAT_IDX_W{1'b0}};
    for (k = `VAT_ENTRIES - 1; k >= 0; k = k - 1)
    begin
        if (match[k])
        begin
            jointHit = 1'b1;
            jointIdx = k[`VAT_IDX_W-1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// micro translators: a hit reuses the cached index of a joint entry

reg                  microHit;
reg [`VAT_IDX_W-1:0] microIdx;
integer m;
always @*
begin
    microHit = 1'b0;
    microIdx = {`VAT_IDX_W{1'b0}};
    if (reqIsData)
    begin
        for (m = 0; m < `VAT_DMICRO; m = m + 1)
        begin
            if (dMicroVal_q[m] & match[dMicroIdx_q[m]])
            begin
                microHit = 1'b1;
                microIdx = dMicroIdx_q[m];
            end
        end
    end
    else
    begin
        for (m = 0; m < `VAT_IMICRO; m = m + 1)
        begin
            if (iMicroVal_q[m] & match[iMicroIdx_q[m]])
            begin
                microHit = 1'b1;
                microIdx = iMicroIdx_q[m];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// segment decode and result forming

wire                  topKernel;
wire                  compatWin;
wire                  directWin;
wire                  lookupHit;
wire [`VAT_IDX_W-1:0] hitIdx;
wire [`VAT_MASK_W-1:0] hitMask;
wire [12:0]           oddSelVec;
wire                  oddHalf;
wire [`VAT_LO_W-1:0]  hitLo;
wire [`VAT_PFN_W-1:0] hitPfn;
wire [`VAT_PA_W-1:0]  mappedPa;
wire [2:0]            directAttr;
wire                  hitUsable;
wire                  hitWritable;

assign topKernel = wideMode & kernelMode & wideKernelAddressing
                 & (reqVaddr[63:62] == `VAT_SEG_KERNEL);
assign compatWin = topKernel & (&reqVaddr[61:31]);
// windows three and four keep the mapped path
assign directWin = compatWin & ~reqVaddr[30];
assign directAttr = (reqVaddr[30:29] == `VAT_WIN_UNCACHE)
                  ? `VAT_ATTR_UNCACH
                  : directWindowCachePolicy;

assign lookupHit = microHit | jointHit;
assign hitIdx    = microHit ? microIdx : jointIdx;
assign hitMask   = entMask[hitIdx];

// one-hot pick of the first virtual bit above the page offset
generate
    for (gi = 0; gi < 13; gi = gi + 1)
    begin : g_odd
        if (gi == 0)
        begin : g_first
            assign oddSelVec[gi] = ~hitMask[0];
        end
        else if (gi == 12)
        begin : g_last
            assign oddSelVec[gi] = hitMask[11];
        end
        else
        begin : g_mid
            assign oddSelVec[gi] = hitMask[gi-1] & ~hitMask[gi];
        end
    end
endgenerate

assign oddHalf = |(reqVaddr[24:12] & oddSelVec);
assign hitLo   = oddHalf ? entOdd[hitIdx] : entEven[hitIdx];
assign hitPfn  = hitLo[`VAT_LO_PFN_HI:`VAT_LO_PFN_LO];
assign mappedPa = {(hitPfn & ~{12'h000, hitMask})
                   | {12'h000, reqVaddr[23:12] & hitMask},
                   reqVaddr[11:0]};
assign hitUsable   = hitLo[`VAT_LO_V];
assign hitWritable = hitLo[`VAT_LO_D];

////////////////////////////////////////////////////////////////////////////
// lookup response; a lookup offered together with an op is dropped

wire lookupGo;
assign lookupGo = reqValid & ~opValid;

always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        rspValid_q    <= 1'b0;
        rspMapped_q   <= 1'b0;
        rspPaddr_q    <= {`VAT_PA_W{1'b0}};
        rspAttr_q     <= 3'h0;
        rspWritable_q <= 1'b0;
        rspUsable_q   <= 1'b0;
        rspUncached_q <= 1'b0;
        rspRefill_q   <= 1'b0;
        rspInvalid_q  <= 1'b0;
        rspModify_q   <= 1'b0;
    end
    else
    begin
        rspValid_q <= lookupGo;
        if (lookupGo & directWin)
        begin
            rspMapped_q   <= 1'b0;
            rspPaddr_q    <= {7'h00, reqVaddr[28:0]};
            rspAttr_q     <= directAttr;
            rspWritable_q <= 1'b1;
            rspUsable_q   <= 1'b1;
            rspUncached_q <= (directAttr == `VAT_ATTR_UNCACH);
            rspRefill_q   <= 1'b0;
            rspInvalid_q  <= 1'b0;
            rspModify_q   <= 1'b0;
        end
        else if (lookupGo)
        begin
            rspMapped_q   <= 1'b1;
            rspPaddr_q    <= lookupHit ? mappedPa : {`VAT_PA_W{1'b0}};
            rspAttr_q     <= lookupHit
                           ? hitLo[`VAT_LO_C_HI:`VAT_LO_C_LO]
                           : 3'h0;
            rspWritable_q <= lookupHit & hitWritable;
            rspUsable_q   <= lookupHit & hitUsable;
            rspUncached_q <= lookupHit & (hitLo[`VAT_LO_C_HI:`VAT_LO_C_LO]
                             == `VAT_ATTR_UNCACH);
            rspRefill_q   <= ~lookupHit;
            rspInvalid_q  <= lookupHit & ~hitUsable;
            rspModify_q   <= lookupHit & hitUsable & reqIsStore
                           & ~hitWritable;
        end
        else
        begin
            rspRefill_q  <= 1'b0;
            rspInvalid_q <= 1'b0;
            rspModify_q  <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// micro translator fill and flush

wire fillMicro;
assign fillMicro = lookupGo & ~directWin & jointHit & ~microHit;

always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        iMicroVal_q <= {`VAT_IMICRO{1'b0}};
        dMicroVal_q <= {`VAT_DMICRO{1'b0}};
        iFillPtr_q  <= 1'b0;
        dFillPtr_q  <= 2'h0;
    end
    else if (doWrite)
    begin
        // stale copies must never outlive a rewritten entry
        iMicroVal_q <= {`VAT_IMICRO{1'b0}};
        dMicroVal_q <= {`VAT_DMICRO{1'b0}};
    end
    else if (fillMicro & reqIsData)
    begin
        dMicroVal_q[dFillPtr_q] <= 1'b1;
        dFillPtr_q <= dFillPtr_q + 2'h1;
    end
    else if (fillMicro)
    begin
        iMicroVal_q[iFillPtr_q] <= 1'b1;
        iFillPtr_q <= ~iFillPtr_q;
    end
end

always @(posedge mclk)
begin
    if (fillMicro & reqIsData)
        dMicroIdx_q[dFillPtr_q] <= jointIdx;
    if (fillMicro & ~reqIsData)
        iMicroIdx_q[iFillPtr_q] <= jointIdx;
end

////////////////////////////////////////////////////////////////////////////
// maintenance: entry writes, random index, probe and read results

always @(posedge mclk)
begin
    if (doWrite & (writeIdx <= `VAT_LAST_INDEX))
    begin
        entMask[writeIdx]   <= opMask;
        entPair[writeIdx]   <= opPair;
        entRegion[writeIdx] <= opRegion;
        entTag[writeIdx]    <= opTag;
        entGlobal[writeIdx] <= lowEntryHalfEven[`VAT_LO_G]
                             & lowEntryHalfOdd[`VAT_LO_G];
        entEven[writeIdx]   <= lowEntryHalfEven;
        entOdd[writeIdx]    <= lowEntryHalfOdd;
    end
end

// free-running down counter stands in for a random choice
always @(posedge mclk or posedge rst)
begin
    if (rst)
        randomIdx_q <= `VAT_LAST_INDEX;
    else if (randomIdx_q == {`VAT_IDX_W{1'b0}})
        randomIdx_q <= `VAT_LAST_INDEX;
    else
        randomIdx_q <= randomIdx_q - 6'h01;
end

wire readOk;
assign readOk = opValid & (opCode == `VAT_OP_READ)
              & (opIndex <= `VAT_LAST_INDEX);

always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        opDone_q     <= 1'b0;
        probeHit_q   <= 1'b0;
        probeIndex_q <= {`VAT_IDX_W{1'b0}};
        rdMask_q     <= {`VAT_MASK_W{1'b0}};
        rdPair_q     <= {`VAT_VPN_W{1'b0}};
        rdRegion_q   <= 2'h0;
        rdTag_q      <= {`VAT_TAG_W{1'b0}};
        rdEven_q     <= {`VAT_LO_W{1'b0}};
        rdOdd_q      <= {`VAT_LO_W{1'b0}};
    end
    else
    begin
        opDone_q <= opValid;
        if (opValid & (opCode == `VAT_OP_PROBE))
        begin
            probeHit_q   <= jointHit;
            probeIndex_q <= jointIdx;
        end
        if (opValid & (opCode == `VAT_OP_READ))
        begin
            // fields only; reserved positions have no storage
            rdMask_q   <= readOk ? entMask[opIndex] : 12'h000;
            rdPair_q   <= readOk ? entPair[opIndex] : 27'h0000000;
            rdRegion_q <= readOk ? entRegion[opIndex] : 2'h0;
            rdTag_q    <= readOk ? entTag[opIndex] : 8'h00;
            rdEven_q   <= readOk ? entEven[opIndex] : 30'h00000000;
            rdOdd_q    <= readOk ? entOdd[opIndex] : 30'h00000000;
        end
    end
end

endmodule

// ===== design/vat_defines.vh
`ifndef VAT_DEFINES_VH
`define VAT_DEFINES_VH

// joint translator geometry
`define VAT_ENTRIES     48
`define VAT_LAST_INDEX  6'h2f
`define VAT_IDX_W       6
`define VAT_MASK_W      12
`define VAT_VPN_W       27
`define VAT_VPN32_W     19
`define VAT_TAG_W       8
`define VAT_PFN_W       24
`define VAT_PA_W        36
// entry half layout {frame, attr, writable, usable, global}
`define VAT_LO_W        30
`define VAT_LO_PFN_HI   29
`define VAT_LO_PFN_LO   6
`define VAT_LO_C_HI     5
`define VAT_LO_C_LO     3
`define VAT_LO_D        2
`define VAT_LO_V        1
`define VAT_LO_G        0
// micro translator sizes
`define VAT_IMICRO      2
`define VAT_DMICRO      4
// maintenance op codes
`define VAT_OP_PROBE    2'h0
`define VAT_OP_READ     2'h1
`define VAT_OP_WINDEX   2'h2
`define VAT_OP_WRANDOM  2'h3
// segment decode
`define VAT_SEG_KERNEL  2'h3
`define VAT_WIN_CACHED  2'h0
`define VAT_WIN_UNCACHE 2'h1
`define VAT_ATTR_UNCACH 3'h2

`endif

// ===== verif/vat_translator_sva.sv
`timescale 1ns/1ns
module vat_translator_sva
(
    input wire        mclk,
    input wire        rst,
    input wire        wideKernelAddressing,
    input wire        kernelMode,
    input wire        wideMode,
    input wire [2:0]  directWindowCachePolicy,
    input wire        reqValid,
    input wire        reqIsStore,
    input wire [63:0] reqVaddr,
    input wire        rspValid_q,
    input wire        rspMapped_q,
    input wire [35:0] rspPaddr_q,
    input wire [2:0]  rspAttr_q,
    input wire        rspWritable_q,
    input wire        rspUsable_q,
    input wire        rspUncached_q,
    input wire        rspRefill_q,
    input wire        rspInvalid_q,
    input wire        rspModify_q,
    input wire        opValid,
    input wire [1:0]  opCode,
    input wire [5:0]  opIndex,
    input wire        opDone_q,
    input wire [26:0] rdPair_q,
    input wire [7:0]  rdTag_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // a lookup beside a maintenance op is dropped, so only this one counts
    wire take = reqValid & ~opValid;
    wire win = wideMode & kernelMode & wideKernelAddressing & (&reqVaddr[63:31]);

    ////////////////////////////////////////////////////////////////////////
    rsp_follows_a: assert property (take |=> rspValid_q)
        else $error("lookup not answered next cycle");
    rsp_dropped_a: assert property (!take |=> !rspValid_q)
        else $error("answer without an accepted lookup");
    op_done_a: assert property (opValid |=> opDone_q)
        else $error("maintenance op not acknowledged");
    cached_win_a: assert property (take && win && !reqVaddr[30] &&
        !reqVaddr[29] |=> !rspMapped_q &&
        rspAttr_q == $past(directWindowCachePolicy) &&
        rspPaddr_q == {7'h0, $past(reqVaddr[28:0])})
        else $error("first window not direct with policy");
    uncached_win_a: assert property (take && win && !reqVaddr[30] &&
        reqVaddr[29] |=> !rspMapped_q && rspAttr_q == 3'h2 && rspUncached_q)
        else $error("second window not direct uncached");
    mapped_win_a: assert property (take && win && reqVaddr[30]
        |=> rspMapped_q)
        else $error("upper windows not translated");
    kernel_gate_a: assert property (take && !wideKernelAddressing
        |=> rspMapped_q)
        else $error("window taken without wide kernel addressing");
    refill_only_a: assert property (rspRefill_q |-> rspValid_q &&
        rspMapped_q && rspPaddr_q == 36'h0 && !rspInvalid_q && !rspModify_q)
        else $error("refill fault mixed with other results");
    modify_cause_a: assert property (rspModify_q |-> rspUsable_q &&
        !rspWritable_q && $past(reqIsStore))
        else $error("modification fault without cause");
    invalid_cause_a: assert property (rspInvalid_q |->
        !rspUsable_q && !rspModify_q)
        else $error("invalid fault on usable page");
    uncached_attr_a: assert property (rspValid_q && !rspRefill_q |->
        rspUncached_q == (rspAttr_q == 3'h2))
        else $error("uncached flag disagrees with attribute");
    read_range_a: assert property (opValid && opCode == 2'h1 &&
        opIndex > 6'h2f |=> rdPair_q == 27'h0 && rdTag_q == 8'h0)
        else $error("read past last entry returned data");
endmodule

bind vat_translator vat_translator_sva chk (.*);

// ===== verif/vat_pipe_model.sv
`timescale 1ns/1ns
module vat_pipe_model
(
    output reg        reqValid,
    output reg        reqIsData,
    output reg        reqIsStore,
    output reg [63:0] reqVaddr
);
    initial
    begin
        reqValid = 1'b0;
        reqIsData = 1'b0;
        reqIsStore = 1'b0;
        reqVaddr = 64'h0;
    end

    // released lines show the inverse so a stale address never passes
    task idle;
        begin
            reqValid = 1'b0;
            reqIsData = ~reqIsData;
            reqIsStore = ~reqIsStore;
            reqVaddr = ~reqVaddr;
        end
    endtask

    task send(input [63:0] va, input d, input s);
        begin
            reqValid = 1'b1;
            reqIsData = d;
            reqIsStore = s;
            reqVaddr = va;
        end
    endtask
endmodule

// ===== verif/vat_translator_test.sv
`timescale 1ns/1ns
`include "vat_defines.vh"
`define CHK(got, want) \
    begin \
        checks = checks + 1; \
        if ((got) !== (want)) \
        begin \
            errCount = errCount + 1; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, want); \
        end \
    end
module vat_translator_test;
    reg         mclk, rst, wideKernelAddressing, kernelMode, wideMode;
    reg  [2:0]  directWindowCachePolicy;
    reg  [7:0]  processTag, opTag;
    reg         opValid;
    reg  [1:0]  opCode, opRegion;
    reg  [5:0]  opIndex;
    reg  [11:0] opMask;
    reg  [26:0] opPair;
    reg  [29:0] lowEntryHalfEven, lowEntryHalfOdd;
    wire        reqValid, reqIsData, reqIsStore;
    wire [63:0] reqVaddr;
    wire        rspValid_q, rspMapped_q, rspWritable_q, rspUsable_q;
    wire        rspUncached_q, rspRefill_q, rspInvalid_q, rspModify_q;
    wire [35:0] rspPaddr_q;
    wire [2:0]  rspAttr_q;
    wire        opDone_q, probeHit_q;
    wire [5:0]  probeIndex_q;
    wire [11:0] rdMask_q;
    wire [26:0] rdPair_q;
    wire [1:0]  rdRegion_q;
    wire [7:0]  rdTag_q;
    wire [29:0] rdEven_q, rdOdd_q;
    reg  [26:0] ePair [0:47];
    reg  [1:0]  eReg [0:47];
    reg  [7:0]  eTag [0:47];
    reg  [29:0] eEven [0:47];
    reg  [29:0] eOdd [0:47];
    integer     seed, i, k, w, errCount, checks, cycles;
    reg  [31:0] r;
    reg  [63:0] va;

    vat_pipe_model pipe (.reqValid(reqValid), .reqIsData(reqIsData),
        .reqIsStore(reqIsStore), .reqVaddr(reqVaddr));
    vat_translator DUT (.*);

    always #10 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("errors %0d checks %0d", errCount, checks);
            if (errCount == 0 && checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            errCount = errCount + 1;
            close_out;
        end
    end

    // lowest matching index wins, as the hardware does
    function [5:0] find(input [63:0] a);
        integer j;
        reg     g;
        begin
            find = 6'h3f;
            for (j = 47; j >= 0; j = j - 1)
            begin
                g = eEven[j][0] & eOdd[j][0];
                if ((wideMode ? (ePair[j] == a[39:13] &&
                    eReg[j] == a[63:62]) : ePair[j][18:0] == a[31:13]) &&
                    (g || eTag[j] == processTag))
                    find = j[5:0];
            end
        end
    endfunction

    task op(input [1:0] c, input [5:0] idx, input [26:0] p, input [1:0] rg,
            input [7:0] t, input [29:0] ev, input [29:0] od);
        begin
            opValid = 1'b1;
            opCode = c;
            opIndex = idx;
            opPair = p;
            opRegion = rg;
            opTag = t;
            lowEntryHalfEven = ev;
            lowEntryHalfOdd = od;
            @(negedge mclk);
            opValid = 1'b0;
            `CHK(opDone_q, 1'b1)
        end
    endtask

    task look(input [63:0] a, input st);
        reg [5:0]  h;
        reg [29:0] lo;
        reg        dir;
        begin
            h = find(a);
            dir = wideMode & kernelMode & wideKernelAddressing &
                  (&a[63:31]) & ~a[30];
            pipe.send(a, a[4], st);
            @(negedge mclk);
            pipe.idle;
            `CHK(rspValid_q, 1'b1)
            `CHK(rspMapped_q, ~dir)
            if (dir)
            begin
                `CHK(rspPaddr_q, {7'h0, a[28:0]})
                `CHK({rspWritable_q, rspUsable_q}, 2'h3)
                `CHK(rspAttr_q, a[29] ? 3'h2 : directWindowCachePolicy)
            end
            else if (h == 6'h3f)
                `CHK(rspRefill_q, 1'b1)
            else
            begin
                lo = a[12] ? eOdd[h] : eEven[h];
                `CHK(rspRefill_q, 1'b0)
                `CHK(rspPaddr_q, {lo[29:6], a[11:0]})
                `CHK(rspAttr_q, lo[5:3])
                `CHK({rspWritable_q, rspUsable_q}, lo[2:1])
                `CHK(rspUncached_q, lo[5:3] == 3'h2)
                `CHK(rspInvalid_q, ~lo[1])
                `CHK(rspModify_q, lo[1] & st & ~lo[2])
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'hedc7;
        errCount = 0;
        checks = 0;
        cycles = 0;
        mclk = 1'b0;
        rst = 1'b1;
        wideKernelAddressing = 1'b1;
        kernelMode = 1'b1;
        wideMode = 1'b1;
        directWindowCachePolicy = 3'h3;
        processTag = 8'h0;
        opMask = 12'h0;
        op_idle: opValid = 1'b0;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < 48; i = i + 1)
        begin
            r = $random(seed);
            ePair[i] = {1'b0, r[19:0], i[5:0]};
            eReg[i] = (r[21:20] == 2'h2) ? 2'h3 : r[21:20];
            eTag[i] = r[29:22];
            r = $random(seed);
            eEven[i] = r[29:0];
            r = $random(seed);
            eOdd[i] = r[29:0];
            op(`VAT_OP_WINDEX, i[5:0], ePair[i], eReg[i], eTag[i], eEven[i],
               eOdd[i]);
        end
        for (i = 0; i < 48; i = i + 1)
        begin
            op(`VAT_OP_READ, i[5:0], 27'h0, 2'h0, 8'h0, 30'h0, 30'h0);
            `CHK(rdPair_q, ePair[i])
            `CHK(rdRegion_q, eReg[i])
            `CHK({rdTag_q, rdMask_q}, {eTag[i], 12'h0})
            `CHK({rdEven_q[29:1], rdOdd_q[29:1]}, {eEven[i][29:1], eOdd[i][29:1]})
        end
        op(`VAT_OP_READ, 6'h30, 27'h0, 2'h0, 8'h0, 30'h0, 30'h0);
        `CHK({rdPair_q, rdTag_q, rdEven_q}, 65'h0)
        op(`VAT_OP_PROBE, 6'h0, ePair[9], eReg[9], eTag[9], 30'h0, 30'h0);
        `CHK({probeHit_q, probeIndex_q}, 7'h49)
        op(`VAT_OP_PROBE, 6'h0, 27'h4000000, 2'h0, 8'h0, 30'h0, 30'h0);
        `CHK(probeHit_q, 1'b0)
        r = $random(seed);
        op(`VAT_OP_WRANDOM, 6'h0, {1'b1, r[25:0]}, 2'h0, r[7:0], r[29:0],
           ~r[29:0]);
        op(`VAT_OP_PROBE, 6'h0, {1'b1, r[25:0]}, 2'h0, r[7:0], 30'h0, 30'h0);
        `CHK({probeHit_q, probeIndex_q <= 6'h2f}, 2'h3)
        k = probeIndex_q;
        ePair[k] = {1'b1, r[25:0]};
        eReg[k] = 2'h0;
        eTag[k] = r[7:0];
        eEven[k] = r[29:0];
        eOdd[k] = ~r[29:0];
        for (w = 0; w < 8; w = w + 1)
        begin
            r = $random(seed);
            directWindowCachePolicy = r[31:29];
            wideKernelAddressing = w[2];
            look({32'hffffffff, 1'b1, w[1:0], r[28:0]}, r[29]);
        end
        wideKernelAddressing = 1'b1;
        for (w = 0; w < 2; w = w + 1)
        begin
            processTag = eTag[3];
            va = {eReg[3], 22'h0, ePair[3], 8'h0, w[0], 4'h0};
            look(va, 1'b0);
            r = $random(seed);
            eEven[3] = r[29:0];
            op(`VAT_OP_WINDEX, 6'h3, ePair[3], eReg[3], eTag[3], eEven[3],
               eOdd[3]);
            look(va, 1'b0);
        end
        for (i = 0; i < 300; i = i + 1)
        begin
            r = $random(seed);
            k = r[7:0] % 48;
            wideMode = (i < 250);
            processTag = r[8] ? eTag[k] : r[31:24];
            va = {eReg[k] ^ {1'b0, r[9] & r[10]}, 22'h0, ePair[k], r[22:10]};
            if (i % 5 == 0)
                va[39:20] = r[31:12];
            if (!wideMode)
                va = {32'h0, ePair[k][18:0], r[22:10]};
            look(va, r[23]);
        end
        close_out;
    end
endmodule
